// [hsb_breaker.sv]
`timescale 1ns/1ns
`default_nettype none

`include "hsb_cfg.svh"

// Overview of operation
// - enable register holds channel a/b enable bits
// - input state bit0 shows enable pin level
// - input state bits 7:6 show policy pin
// - both trip comparators always active
// - below both thresholds gate drive stays high
// - either threshold exceeded pulls gate drive down
// - fast threshold from level code and range
// - level code spans 40 to 100 percent
// - slow threshold is fast divided by ratio
// - ratio register bits 1:0, resets to 200
// - slow trip delayed by overdrive, fast immediate
// - range loaded from pin, overridable anytime
// - settings change on the fly, no restart
// - overcurrent shutdown asserts open-drain fault output
// - range code 10=25mV, 01=50mV, 00=100mV
module hsb_breaker
    import hsb_pkg::*;
#(
    parameter int unsigned SLOW_BASE_CYC = `HSB_SLOW_BASE_CYC
) (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic [7:0]  reg_addr_in,
    input  wire logic        reg_wr_in,
    input  wire logic [7:0]  reg_wdata_in,
    output logic      [7:0]  reg_rdata_out,
    input  wire logic        enable_level_pin_in,
    input  wire logic [1:0]  critical_policy_pin_in,
    input  wire logic [1:0]  range_select_pin_in,
    input  wire logic [16:0] sense_uv_a_in,
    input  wire logic [16:0] sense_uv_b_in,
    output logic      [1:0]  fet_drive_out,
    output logic      [1:0]  fet_pulldown_out,
    output logic             trip_flag_out_o,
    output logic             trip_flag_oe_out,
    output logic      [16:0] fast_uv_out,
    output logic      [16:0] slow_uv_out
);
    // pin synchronisers: three stages, enable and policy change taken when 2nd and 3rd agree
    logic [2:0] en_sync_r;
    logic [2:0] en_sync_nxt;
    logic       en_pin_r;
    logic       en_pin_nxt;
    logic [5:0] pol_sync_r;
    logic [5:0] pol_sync_nxt;
    logic [1:0] pol_r;
    logic [1:0] pol_nxt;
    logic [5:0] rng_sync_r;
    logic [5:0] rng_sync_nxt;
    logic       strap_done_r;
    logic       strap_done_nxt;
    logic [1:0] strap_cnt_r;
    logic [1:0] strap_cnt_nxt;

    always_comb begin
        en_sync_nxt  = {en_sync_r[1:0], enable_level_pin_in};
        pol_sync_nxt = {pol_sync_r[3:0], critical_policy_pin_in};
        rng_sync_nxt = {rng_sync_r[3:0], range_select_pin_in};
        en_pin_nxt   = en_pin_r;
        pol_nxt      = pol_r;
        if (en_sync_r[1] == en_sync_r[2]) begin
            en_pin_nxt = en_sync_r[2];
        end
        if (pol_sync_r[3:2] == pol_sync_r[5:4]) begin
            pol_nxt = pol_sync_r[5:4];
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            en_sync_r  <= 3'h0;
            pol_sync_r <= 6'h00;
            rng_sync_r <= 6'h00;
            en_pin_r   <= 1'b0;
            pol_r      <= 2'h0;
        end else begin
            en_sync_r  <= en_sync_nxt;
            pol_sync_r <= pol_sync_nxt;
            rng_sync_r <= rng_sync_nxt;
            en_pin_r   <= en_pin_nxt;
            pol_r      <= pol_nxt;
        end
    end

    // registers
    logic [1:0] ratio_r;
    logic [1:0] ratio_nxt;
    logic [1:0] enable_r;
    logic [1:0] enable_nxt;
    logic [1:0] range_r;
    logic [1:0] range_nxt;
    logic [7:0] level_r;
    logic [7:0] level_nxt;

    localparam logic [7:0] RATIO_RST  = `HSB_RST_RATIO;
    localparam logic [7:0] ENABLE_RST = `HSB_RST_ENABLE;

    always_comb begin
        ratio_nxt      = ratio_r;
        enable_nxt     = enable_r;
        range_nxt      = range_r;
        level_nxt      = level_r;
        strap_cnt_nxt  = strap_cnt_r;
        strap_done_nxt = strap_done_r;
        // the strap is caught once the synchroniser has filled after reset
        if (!strap_done_r) begin
            strap_cnt_nxt = strap_cnt_r + 2'h1;
            if (strap_cnt_r == 2'h3) begin
                strap_done_nxt = 1'b1;
                range_nxt      = rng_sync_r[5:4];
            end
        end
        if (reg_wr_in) begin
            case (reg_addr_in)
                `HSB_ADDR_RATIO:  ratio_nxt  = reg_wdata_in[1:0];
                `HSB_ADDR_ENABLE: enable_nxt = reg_wdata_in[1:0];
                `HSB_ADDR_RANGE: begin
                    if (reg_wdata_in[1:0] != 2'b11) begin
                        range_nxt      = reg_wdata_in[1:0];
                        strap_done_nxt = 1'b1;
                    end
                end
                `HSB_ADDR_LEVEL:  level_nxt  = reg_wdata_in;
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            ratio_r      <= RATIO_RST[1:0];
            enable_r     <= ENABLE_RST[1:0];
            range_r      <= `HSB_RANGE_100;
            level_r      <= `HSB_RST_LEVEL;
            strap_cnt_r  <= 2'h0;
            strap_done_r <= 1'b0;
        end else begin
            ratio_r      <= ratio_nxt;
            enable_r     <= enable_nxt;
            range_r      <= range_nxt;
            level_r      <= level_nxt;
            strap_cnt_r  <= strap_cnt_nxt;
            strap_done_r <= strap_done_nxt;
        end
    end

    always_comb begin
        case (reg_addr_in)
            `HSB_ADDR_RATIO:   reg_rdata_out = {6'h00, ratio_r};
            `HSB_ADDR_INSTATE: reg_rdata_out = {pol_r, 5'h00, en_pin_r};
            `HSB_ADDR_RANGE:   reg_rdata_out = {6'h00, range_r};
            `HSB_ADDR_ENABLE:  reg_rdata_out = {6'h00, enable_r};
            `HSB_ADDR_LEVEL:   reg_rdata_out = level_r;
            default:           reg_rdata_out = 8'h00;
        endcase
    end

    // thresholds, recomputed every cycle so changes apply live
    hsb_uv_t    fs_uv;
    logic [8:0] ratio_pct;
    logic [31:0] fast_calc;
    logic [31:0] slow_calc;

    always_comb begin
        case (range_r)
            `HSB_RANGE_25: fs_uv = `HSB_FS_25_UV;
            `HSB_RANGE_50: fs_uv = `HSB_FS_50_UV;
            default:       fs_uv = `HSB_FS_100_UV;
        endcase
        case (ratio_r)
            2'b00:   ratio_pct = `HSB_RATIO_00_PCT;
            2'b01:   ratio_pct = `HSB_RATIO_01_PCT;
            2'b10:   ratio_pct = `HSB_RATIO_10_PCT;
            default: ratio_pct = `HSB_RATIO_11_PCT;
        endcase
        // code 0 -> 40 %, code 255 -> 100 % of full scale
        fast_calc = ({15'h0, fs_uv} * {15'h0, `HSB_SPAN_LO_PCT}) / 32'd100
                  + ({15'h0, fs_uv} * (`HSB_SPAN_HI_PCT - `HSB_SPAN_LO_PCT)
                     * {24'h0, level_r}) / 32'd25500;
        slow_calc = (fast_calc * 32'd100) / {23'h0, ratio_pct};
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            fast_uv_out <= 17'h0;
            slow_uv_out <= 17'h0;
        end else begin
            fast_uv_out <= fast_calc[16:0];
            slow_uv_out <= slow_calc[16:0];
        end
    end

    // per-channel comparators and on/off control
    logic [1:0] tripped;

    genvar ch;
    generate
        for (ch = 0; ch < 2; ch++) begin : g_ch
            hsb_chan_e  st_r;
            hsb_chan_e  st_nxt;
            logic       fast_hit;
            logic       slow_hit;
            logic [16:0] over;
            logic [7:0]  step;
            logic        slow_exp;
            logic [16:0] sense;

            assign sense    = (ch == 0) ? sense_uv_a_in : sense_uv_b_in;
            assign fast_hit = (sense > fast_uv_out);
            assign slow_hit = (sense > slow_uv_out);
            assign over     = sense - slow_uv_out;
            // overdrive step in units of 512 uV above the slow threshold, capped at 255
            assign step     = !slow_hit ? 8'h00 :
                              ((over >> 9) > 17'd254) ? 8'hFF : 8'(over >> 9) + 8'h01;

            hsb_slow_timer #(
                .LIMIT (SLOW_BASE_CYC)
            ) u_slow (
                .ref_clk_in  (ref_clk_in),
                .reset_in    (reset_in),
                .clear_in    (st_r != HSB_ON),
                .step_in     (step),
                .expired_out (slow_exp)
            );

            always_comb begin
                st_nxt = st_r;
                case (st_r)
                    HSB_OFF: begin
                        if (enable_r[ch] && en_pin_r) begin
                            st_nxt = HSB_ON;
                        end
                    end
                    HSB_ON: begin
                        if (fast_hit || slow_exp) begin
                            st_nxt = HSB_TRIP;
                        end else if (!(enable_r[ch] && en_pin_r)) begin
                            st_nxt = HSB_OFF;
                        end
                    end
                    HSB_TRIP: begin
                        // latched off until software drops the enable bit
                        if (!enable_r[ch]) begin
                            st_nxt = HSB_OFF;
                        end
                    end
                    default: st_nxt = HSB_OFF;
                endcase
            end

            always_ff @(posedge ref_clk_in) begin
                if (reset_in) begin
                    st_r <= HSB_OFF;
                end else begin
                    st_r <= st_nxt;
                end
            end

            assign fet_drive_out[ch]    = (st_r == HSB_ON);
            assign fet_pulldown_out[ch] = (st_r != HSB_ON);
            assign tripped[ch]          = (st_r == HSB_TRIP);
        end
    endgenerate

    // open-drain fault: drive low while any channel is tripped
    assign trip_flag_out_o  = 1'b0;
    assign trip_flag_oe_out = |tripped;
endmodule

`default_nettype wire

// [hsb_cfg.svh]
`ifndef HSB_CFG_SVH
`define HSB_CFG_SVH

// register byte addresses on the device's register port
`define HSB_ADDR_RATIO      8'h30
`define HSB_ADDR_INSTATE    8'h32
`define HSB_ADDR_RANGE      8'h33
`define HSB_ADDR_ENABLE     8'h3B
`define HSB_ADDR_LEVEL      8'h2E

// reset values
`define HSB_RST_RATIO       8'h0F
`define HSB_RST_ENABLE      8'h00
`define HSB_RST_LEVEL       8'hBF

// field positions
`define HSB_EN_A_BIT        0
`define HSB_EN_B_BIT        1
`define HSB_INSTATE_PIN_BIT 0
`define HSB_INSTATE_POL_LO  6

// range codes in the override register
`define HSB_RANGE_25        2'b10
`define HSB_RANGE_50        2'b01
`define HSB_RANGE_100       2'b00

// full-scale sense ranges in microvolts
`define HSB_FS_25_UV        17'd25000
`define HSB_FS_50_UV        17'd50000
`define HSB_FS_100_UV       17'd100000

// fast-trip span: 40 % to 100 % of full scale
`define HSB_SPAN_LO_PCT     17'd40
`define HSB_SPAN_HI_PCT     17'd100

// slow-trip ratios in percent
`define HSB_RATIO_00_PCT    9'd125
`define HSB_RATIO_01_PCT    9'd150
`define HSB_RATIO_10_PCT    9'd175
`define HSB_RATIO_11_PCT    9'd200

// clock and slow-trip timing
`define HSB_CLK_MHZ         125
`define HSB_SLOW_BASE_US    100
`define HSB_SLOW_BASE_CYC   (`HSB_SLOW_BASE_US * `HSB_CLK_MHZ)

`endif

// [hsb_pkg.sv]
`default_nettype none

package hsb_pkg;

    typedef enum logic [2:0] {
        HSB_OFF  = 3'b001,
        HSB_ON   = 3'b010,
        HSB_TRIP = 3'b100
    } hsb_chan_e;

    typedef logic [16:0] hsb_uv_t;

endpackage

`default_nettype wire

// [hsb_slow_timer.sv]
`timescale 1ns/1ns
`default_nettype none

// slow-trip delay: the timer advances by the overdrive step each cycle,
// so larger overdrive reaches the limit sooner; it leaks back to zero
// once the excursion ends, so short small excursions never trip
module hsb_slow_timer #(
    parameter int unsigned LIMIT = 12500
) (
    input  wire logic        ref_clk_in,
    input  wire logic        reset_in,
    input  wire logic        clear_in,
    input  wire logic [7:0]  step_in,
    output logic             expired_out
);
    logic [31:0] acc_r;
    logic [31:0] acc_nxt;

    always_comb begin
        acc_nxt = acc_r;
        if (clear_in) begin
            acc_nxt = 32'h0;
        end else if (step_in != 8'h00) begin
            acc_nxt = acc_r + {24'h0, step_in};
        end else if (acc_r != 32'h0) begin
            acc_nxt = acc_r - 32'h1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (reset_in) begin
            acc_r <= 32'h0;
        end else begin
            acc_r <= acc_nxt;
        end
    end

    assign expired_out = (acc_r >= LIMIT);
endmodule

`default_nettype wire

// [hsb_fet_model.sv]
`timescale 1ns/1ns
`default_nettype none
// pass switch with its sense resistor: no load current flows once the gate is off,
// so the sensed drop falls to zero instead of holding the last value
module hsb_fet_model (
    input  wire logic        gate_in,
    input  wire logic [16:0] load_uv_in,
    output logic      [16:0] sense_uv_out
);
    assign sense_uv_out = gate_in ? load_uv_in : 17'h0;
endmodule
`default_nettype wire

// [hsb_breaker_properties.sv]
`timescale 1ns/1ns
`default_nettype none
`include "hsb_cfg.svh"
module hsb_breaker_chk #(
    parameter int unsigned SLOW_BASE_CYC = 12500
) (
    input wire logic        ref_clk_in,
    input wire logic        reset_in,
    input wire logic [7:0]  reg_addr_in,
    input wire logic        reg_wr_in,
    input wire logic [7:0]  reg_wdata_in,
    input wire logic [7:0]  reg_rdata_out,
    input wire logic        enable_level_pin_in,
    input wire logic [16:0] sense_uv_a_in,
    input wire logic [1:0]  fet_drive_out,
    input wire logic [1:0]  fet_pulldown_out,
    input wire logic        trip_flag_out_o,
    input wire logic        trip_flag_oe_out,
    input wire logic [16:0] fast_uv_out,
    input wire logic [16:0] slow_uv_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (reset_in);
    // zero threshold means not yet computed after reset
    wire fast_a = fast_uv_out != 17'h0 && sense_uv_a_in > fast_uv_out;
    pull_inverse_a: assert property (fet_pulldown_out == ~fet_drive_out)
        else $error("pulldown not inverse of gate drive");
    fast_trip_a: assert property (fet_drive_out[0] && fast_a |=> !fet_drive_out[0]
        && trip_flag_oe_out)
        else $error("fast trip did not shut channel a");
    flag_low_a: assert property (trip_flag_out_o == 1'h0)
        else $error("fault pin data not low");
    slow_ratio_a: assert property (fast_uv_out != 17'h0 |-> slow_uv_out < fast_uv_out
        && {1'h0, slow_uv_out, 1'h0} + 19'h4 >= {2'h0, fast_uv_out})
        else $error("slow threshold outside ratio span");
    fast_span_a: assert property (fast_uv_out != 17'h0 |-> fast_uv_out >= 17'd10000
        && fast_uv_out <= 17'd100000)
        else $error("fast threshold outside span");
    range_low_a: assert property (reg_wr_in && reg_addr_in == `HSB_ADDR_RANGE
        && reg_wdata_in[1:0] == 2'h2 ##1 !reg_wr_in |=> fast_uv_out <= 17'd25000)
        else $error("low range not applied");
    enable_wr_a: assert property (reg_wr_in && reg_addr_in == `HSB_ADDR_ENABLE ##1
        reg_addr_in == `HSB_ADDR_ENABLE |-> reg_rdata_out == {6'h0, $past(reg_wdata_in[1:0])})
        else $error("enable register readback wrong");
    state_bits_a: assert property (enable_level_pin_in [*8] ##0 reg_addr_in == `HSB_ADDR_INSTATE
        |-> reg_rdata_out[5:0] == 6'h1)
        else $error("input state bits wrong");
    pin_off_a: assert property ((!enable_level_pin_in) [*8] |-> fet_drive_out == 2'h0)
        else $error("channel on with enable pin low");
    fast_trip_c: cover property (fet_drive_out[0] && fast_a);
    slow_trip_c: cover property (fet_drive_out[0] && !fast_a && sense_uv_a_in > slow_uv_out
        ##1 !fet_drive_out[0]);
    both_on_c: cover property (fet_drive_out == 2'h3);
endmodule
bind hsb_breaker hsb_breaker_chk #(.SLOW_BASE_CYC(SLOW_BASE_CYC)) i_hsb_breaker_chk (
    .ref_clk_in, .reset_in, .reg_addr_in, .reg_wr_in, .reg_wdata_in, .reg_rdata_out,
    .enable_level_pin_in, .sense_uv_a_in, .fet_drive_out, .fet_pulldown_out,
    .trip_flag_out_o, .trip_flag_oe_out, .fast_uv_out, .slow_uv_out);
`default_nettype wire

// [hsb_breaker_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module hsb_breaker_tb;
    logic        ref_clk_in = 0;
    logic        reset_in   = 1;
    logic        wr         = 0;
    logic        pin        = 0;
    logic        flag, flag_oe;
    logic [7:0]  addr = 0, wdata = 0, rdata;
    logic [1:0]  policy = 0, strap = 2'h2, drive, pull;
    logic [16:0] load_a = 0, load_b = 0, sense_a, sense_b, fast, slow;
    int          err_count = 0, comparisons = 0, cycles = 0, t;
    int          regs_m[int];
    int          fs_uv[$] = '{100000, 50000, 25000};
    int          ratio_pct[$] = '{125, 150, 175, 200};
    always #4 ref_clk_in = ~ref_clk_in;
    hsb_breaker #(.SLOW_BASE_CYC(50)) i_hsb_breaker (.ref_clk_in(ref_clk_in),
        .reset_in(reset_in), .reg_addr_in(addr), .reg_wr_in(wr), .reg_wdata_in(wdata),
        .reg_rdata_out(rdata), .enable_level_pin_in(pin), .critical_policy_pin_in(policy),
        .range_select_pin_in(strap), .sense_uv_a_in(sense_a), .sense_uv_b_in(sense_b),
        .fet_drive_out(drive), .fet_pulldown_out(pull), .trip_flag_out_o(flag),
        .trip_flag_oe_out(flag_oe), .fast_uv_out(fast), .slow_uv_out(slow));
    hsb_fet_model i_hsb_fet_model (.gate_in(drive[0]), .load_uv_in(load_a), .sense_uv_out(sense_a));
    hsb_fet_model i_hsb_fet_model_b (.gate_in(drive[1]), .load_uv_in(load_b), .sense_uv_out(sense_b));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    always @(posedge ref_clk_in) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            tally_and_finish();
        end
    end
    task automatic check(string name, logic [31:0] seen, logic [31:0] exp, int tol = 0);
        comparisons++;
        if (^seen === 1'bx || (seen > exp ? seen - exp : exp - seen) > tol) begin
            err_count++;
            $display("unexpected %s expected %0d seen %0d", name, exp, seen);
        end
    endtask
    // one idle cycle after each write keeps the strobe to one assignment per step
    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1;
        @(posedge ref_clk_in);
        wr <= 0;
        @(posedge ref_clk_in);
        case (a)
            8'h30, 8'h3B: regs_m[a] = d & 3;
            8'h2E: regs_m[a] = d;
            8'h33: if (d[1:0] != 2'h3) regs_m[a] = d & 3;
            default: ;
        endcase
    endtask
    task automatic rd_chk(logic [7:0] a, logic [7:0] mask);
        addr <= a;
        @(posedge ref_clk_in);
        check("rdata", rdata & mask, regs_m[a] & mask);
    endtask
    function automatic int exp_fast();
        int fs;
        fs = fs_uv[regs_m['h33]];
        return (fs * 40 + fs * 60 * regs_m['h2E] / 255) / 100;
    endfunction
    task automatic thr_chk();
        repeat (2) @(posedge ref_clk_in);
        check("fast", fast, exp_fast(), 3);
        check("slow", slow, exp_fast() * 100 / ratio_pct[regs_m['h30]], 3);
    endtask
    initial begin
        regs_m = '{'h30: 3, 'h3B: 0, 'h2E: 'hBF, 'h33: 2};
        void'($urandom(7613));
        repeat (2) @(posedge ref_clk_in);
        reset_in <= 0;
        repeat (8) @(posedge ref_clk_in);
        rd_chk(8'h30, 8'hFF);
        rd_chk(8'h3B, 8'hFF);
        rd_chk(8'h33, 8'h03);
        thr_chk();
        wr_reg(8'h55, 8'hFF);
        // host order: ratio, then range, then level code
        for (int i = 0; i < 12; i++) begin
            wr_reg(8'h30, 8'(i % 4) | 8'hFC);
            wr_reg(8'h33, 8'(i % 3));
            wr_reg(8'h2E, 8'($urandom));
            thr_chk();
            rd_chk(8'h30, 8'hFF);
        end
        wr_reg(8'h33, 8'h3);
        rd_chk(8'h33, 8'h03);
        for (int i = 0; i < 6; i++) begin
            pin <= i[0];
            policy <= 2'(i / 2);
            repeat (8) @(posedge ref_clk_in);
            wr_reg(8'h32, 8'hFF);
            regs_m['h32] = (i / 2) * 64 + i % 2;
            rd_chk(8'h32, 8'hFF);
        end
        // 40 mV fast trip: the 50 mV range is the smallest one above it
        wr_reg(8'h30, 8'h3);
        wr_reg(8'h33, 8'h1);
        wr_reg(8'h2E, 8'hAA);
        thr_chk();
        load_a <= 10000;
        load_b <= 10000;
        wr_reg(8'h3B, 8'h3);
        repeat (6) @(posedge ref_clk_in);
        check("drive", drive, 3);
        check("oe", flag_oe, 0);
        load_a <= 60000;
        repeat (2) @(posedge ref_clk_in);
        check("drive", drive, 2);
        check("pull", pull, 1);
        check("oe", flag_oe, 1);
        check("flag", flag, 0);
        load_a <= 10000;
        wr_reg(8'h3B, 8'h2);
        // the state register leaves the trip state one edge after the enable write lands
        @(posedge ref_clk_in);
        check("oe", flag_oe, 0);
        wr_reg(8'h3B, 8'h3);
        repeat (6) @(posedge ref_clk_in);
        // a one-cycle small excursion must be ignored by the slow path
        load_a <= 30000;
        @(posedge ref_clk_in);
        load_a <= 10000;
        repeat (4) @(posedge ref_clk_in);
        check("drive", drive, 3);
        load_a <= 30000;
        t = 0;
        while (drive[0] === 1'b1 && t < 500) begin
            @(posedge ref_clk_in);
            t++;
        end
        check("slow_trip", (t > 1 && t < 500), 1);
        check("oe", flag_oe, 1);
        load_a <= 10000;
        wr_reg(8'h3B, 8'h0);
        wr_reg(8'h3B, 8'h3);
        pin <= 0;
        repeat (8) @(posedge ref_clk_in);
        check("drive", drive, 0);
        check("oe", flag_oe, 0);
        tally_and_finish();
    end
endmodule
`default_nettype wire
